// File: hdl/tgsp_cfg.svh
// Register map, field positions and reset values of the transceiver pin port
`ifndef TGSP_CFG_SVH
`define TGSP_CFG_SVH

// Register word offsets
`define TGSP_ADDR_W 6
`define TGSP_ADDR_CTRL 6'h09
`define TGSP_ADDR_DIR 6'h0b
`define TGSP_ADDR_OUT 6'h0c
`define TGSP_ADDR_IN 6'h28

// Word width and pin count
`define TGSP_DATA_W 16
`define TGSP_PINS 7
`define TGSP_DRV_W 2

// Control word fields
`define TGSP_CTRL_ALT_BIT 6

// Direction word fields
`define TGSP_DIR_OEN_LSB 0
`define TGSP_DIR_IEN_LSB 7
`define TGSP_DIR_DRV_LSB 14

// Output word fields
`define TGSP_OUT_VAL_LSB 0
`define TGSP_OUT_DRV_LSB 8

// Input word fields
`define TGSP_IN_VAL_LSB 0

// Reset values
`define TGSP_RST_OEN 7'h00
`define TGSP_RST_IEN 7'h7f
`define TGSP_RST_VAL 7'h00
`define TGSP_RST_DRV 2'h0
`define TGSP_RST_WORD 16'h0000

// Pins taken over in status mode
`define TGSP_PIN_BUSY 0
`define TGSP_PIN_RESULT 1

`endif

// File: hdl/tgsp_pkg.sv
// Types shared by the transceiver pin port files
`include "tgsp_cfg.svh"

package tgsp_pkg;

   // Register access from the transceiver's register port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [`TGSP_ADDR_W-1:0] addr;
      logic [`TGSP_DATA_W-1:0] wdata;
   } tgsp_req_t;

   // Sequence status from the transceiver core
   typedef struct packed {
      logic active;
      logic is_rx;
      logic is_cca;
      logic crc_ok;
      logic cca_ok;
      logic error;
      logic sleep;
   } tgsp_seq_t;

   // Pin pad controls
   typedef struct packed {
      logic [`TGSP_PINS-1:0] level;
      logic [`TGSP_PINS-1:0] oe_n;
   } tgsp_pad_t;

   // Kind of the sequence in flight
   typedef enum logic [1:0] {
      TGSP_KIND_NONE,
      TGSP_KIND_RX,
      TGSP_KIND_CCA,
      TGSP_KIND_TX
   } tgsp_kind_t;

endpackage

// File: hdl/tgsp_status_ind.sv
// Busy and result indicator logic for the two status pins
`timescale 1ns/1ps
`default_nettype none
`include "tgsp_cfg.svh"

module tgsp_status_ind (
   input wire logic clk,
   input wire logic rst,
   input wire logic soft_rst,
   input wire tgsp_pkg::tgsp_seq_t seq,
   output logic busy_q,
   output logic result_q
);

   // ==========================================
   // Sequence tracking
   tgsp_pkg::tgsp_kind_t kind_q;
   logic busy_d;
   logic fall;
   logic rise;

   assign busy_d = seq.active & ~seq.sleep;
   assign rise = busy_d & ~busy_q;
   assign fall = ~busy_d & busy_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_q <= 1'b0;
      end else if (soft_rst) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= busy_d;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         kind_q <= tgsp_pkg::TGSP_KIND_NONE;
      end else if (soft_rst) begin
         kind_q <= tgsp_pkg::TGSP_KIND_NONE;
      end else if (rise) begin
         if (seq.is_rx) begin
            kind_q <= tgsp_pkg::TGSP_KIND_RX;
         end else if (seq.is_cca) begin
            kind_q <= tgsp_pkg::TGSP_KIND_CCA;
         end else begin
            kind_q <= tgsp_pkg::TGSP_KIND_TX;
         end
      end
   end

   // ==========================================
   // Result latch
   // Error ends give low, which the MCU must ignore anyway
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result_q <= 1'b0;
      end else if (soft_rst) begin
         result_q <= 1'b0;
      end else if (rise) begin
         result_q <= 1'b0;
      end else if (fall) begin
         if (seq.error) begin
            result_q <= 1'b0;
         end else begin
            case (kind_q)
               tgsp_pkg::TGSP_KIND_RX: begin
                  result_q <= seq.crc_ok;
               end
               tgsp_pkg::TGSP_KIND_CCA: begin
                  result_q <= seq.cca_ok;
               end
               default: begin
                  result_q <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// File: hdl/tgsp_port.sv
// Seven-pin general purpose port with status indicator mode
`timescale 1ns/1ps
`default_nettype none
`include "tgsp_cfg.svh"

// How it works
// - Seven pins, each independently input or output
// - Reset disables drivers, pins leave as inputs
// - Pins never raise an interrupt request
// - Outputs keep driving through sleep modes
// - Separate enables; inputs 1, outputs 0 after reset
// - Both enables set means input, driver off
// - Two 2-bit drive fields, 00 weakest
// - Output value bit sets driven level
// - Input register shows level of input pins
// - Status select turns pins one, two over
// - Pin one high during any sequence while awake
// - Pin one low while asleep
// - Falling pin one latches frame check result
// - Falling pin one latches assessment result
// - Error ends give no valid result
// - No programmable pull-ups on pins
module tgsp_port #(
   parameter int N_PINS = `TGSP_PINS
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic soft_rst,
   input wire tgsp_pkg::tgsp_req_t req,
   output logic [`TGSP_DATA_W-1:0] rdata_q,
   output logic rvalid_q,
   input wire tgsp_pkg::tgsp_seq_t seq,
   input wire logic [N_PINS-1:0] pin_in,
   output tgsp_pkg::tgsp_pad_t pad_q,
   output logic [`TGSP_DRV_W-1:0] low_group_drive_strength_q,
   output logic [`TGSP_DRV_W-1:0] high_group_drive_strength_q,
   output logic irq_req_q
);

   // ==========================================
   // Helpers
   // Input enable overrides output enable
   function automatic logic [N_PINS-1:0] drive_mask(
      input logic [N_PINS-1:0] oen,
      input logic [N_PINS-1:0] ien
   );
      drive_mask = oen & ~ien;
   endfunction

   function automatic logic addr_hit(
      input logic [`TGSP_ADDR_W-1:0] addr,
      input logic [`TGSP_ADDR_W-1:0] target
   );
      addr_hit = (addr == target);
   endfunction

   // ==========================================
   // Field access
   // Variable base keeps one helper for every pin field
   function automatic logic [N_PINS-1:0] pin_field(
      input logic [`TGSP_DATA_W-1:0] word,
      input int lsb
   );
      pin_field = word[lsb +: N_PINS];
   endfunction

   // Drive field of a register word
   function automatic logic [`TGSP_DRV_W-1:0] drv_field(
      input logic [`TGSP_DATA_W-1:0] word,
      input int lsb
   );
      drv_field = word[lsb +: `TGSP_DRV_W];
   endfunction

   // Read packing; bits outside the field pass through
   function automatic logic [`TGSP_DATA_W-1:0] put_pins(
      input logic [`TGSP_DATA_W-1:0] word,
      input int lsb,
      input logic [N_PINS-1:0] bits
   );
      put_pins = word;
      put_pins[lsb +: N_PINS] = bits;
   endfunction

   // Drive field packing
   function automatic logic [`TGSP_DATA_W-1:0] put_drv(
      input logic [`TGSP_DATA_W-1:0] word,
      input int lsb,
      input logic [`TGSP_DRV_W-1:0] bits
   );
      put_drv = word;
      put_drv[lsb +: `TGSP_DRV_W] = bits;
   endfunction

   // ==========================================
   // Register state
   logic alt_en_q;
   logic [N_PINS-1:0] oen_q;
   logic [N_PINS-1:0] ien_q;
   logic [N_PINS-1:0] val_q;
   logic [N_PINS-1:0] level_q;
   logic wr_ctrl;
   logic wr_dir;
   logic wr_out;
   logic [`TGSP_DRV_W-1:0] low_drv_d;
   logic [`TGSP_DRV_W-1:0] high_drv_d;
   logic [N_PINS-1:0] oen_d;
   logic [N_PINS-1:0] ien_d;
   logic [N_PINS-1:0] val_d;

   assign wr_ctrl = req.wr & addr_hit(req.addr, `TGSP_ADDR_CTRL);
   assign wr_dir = req.wr & addr_hit(req.addr, `TGSP_ADDR_DIR);
   assign wr_out = req.wr & addr_hit(req.addr, `TGSP_ADDR_OUT);

   // ==========================================
   // Write data fields
   assign oen_d = pin_field(req.wdata, `TGSP_DIR_OEN_LSB);
   assign ien_d = pin_field(req.wdata, `TGSP_DIR_IEN_LSB);
   assign val_d = pin_field(req.wdata, `TGSP_OUT_VAL_LSB);
   assign low_drv_d = drv_field(req.wdata, `TGSP_DIR_DRV_LSB);
   assign high_drv_d = drv_field(req.wdata, `TGSP_OUT_DRV_LSB);

   // ==========================================
   // Control word
   // Only the status select bit is stored; the rest reads zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         alt_en_q <= 1'b0;
      end else if (soft_rst) begin
         alt_en_q <= 1'b0;
      end else if (wr_ctrl) begin
         alt_en_q <= req.wdata[`TGSP_CTRL_ALT_BIT];
      end
   end

   // ==========================================
   // Direction word
   // Enables kept as written; the input override is applied at the pad
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         oen_q <= `TGSP_RST_OEN;
      end else if (soft_rst) begin
         oen_q <= `TGSP_RST_OEN;
      end else if (wr_dir) begin
         oen_q <= oen_d;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ien_q <= `TGSP_RST_IEN;
      end else if (soft_rst) begin
         ien_q <= `TGSP_RST_IEN;
      end else if (wr_dir) begin
         ien_q <= ien_d;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         low_group_drive_strength_q <= `TGSP_RST_DRV;
      end else if (soft_rst) begin
         low_group_drive_strength_q <= `TGSP_RST_DRV;
      end else if (wr_dir) begin
         low_group_drive_strength_q <= low_drv_d;
      end
   end

   // ==========================================
   // Output word
   // Bit seven is not stored and reads zero
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         val_q <= `TGSP_RST_VAL;
      end else if (soft_rst) begin
         val_q <= `TGSP_RST_VAL;
      end else if (wr_out) begin
         val_q <= val_d;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         high_group_drive_strength_q <= `TGSP_RST_DRV;
      end else if (soft_rst) begin
         high_group_drive_strength_q <= `TGSP_RST_DRV;
      end else if (wr_out) begin
         high_group_drive_strength_q <= high_drv_d;
      end
   end

   // ==========================================
   // Input sampling
   // Pins are synchronous here; one flop gives a stable read value
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         level_q <= `TGSP_RST_VAL;
      end else if (soft_rst) begin
         level_q <= `TGSP_RST_VAL;
      end else begin
         level_q <= pin_in;
      end
   end

   // ==========================================
   // Status indicators
   logic busy_q;
   logic result_q;

   tgsp_status_ind u_status (
      .clk(clk),
      .rst(rst),
      .soft_rst(soft_rst),
      .seq(seq),
      .busy_q(busy_q),
      .result_q(result_q)
   );

   // ==========================================
   // Pad drive
   logic [N_PINS-1:0] drive;
   logic [N_PINS-1:0] level_d;

   // Sleep is not looked at here, so drivers stay on through it
   assign drive = drive_mask(oen_q, ien_q);

   always_comb begin
      level_d = val_q;
      if (alt_en_q) begin
         level_d[`TGSP_PIN_BUSY] = busy_q;
         level_d[`TGSP_PIN_RESULT] = result_q;
      end
   end

   // Status pins only reach the pad if software made them outputs
   // Level and enable live in their own registers, one concern each
   logic [N_PINS-1:0] pad_level_q;
   logic [N_PINS-1:0] pad_oe_n_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pad_level_q <= `TGSP_RST_VAL;
      end else if (soft_rst) begin
         pad_level_q <= `TGSP_RST_VAL;
      end else begin
         pad_level_q <= level_d;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pad_oe_n_q <= ~`TGSP_RST_OEN;
      end else if (soft_rst) begin
         pad_oe_n_q <= ~`TGSP_RST_OEN;
      end else begin
         pad_oe_n_q <= ~drive;
      end
   end

   assign pad_q = '{level: pad_level_q, oe_n: pad_oe_n_q};

   // No pull-up control exists in any register

   // ==========================================
   // Interrupt request
   // The port has no event source, so the request stays low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_req_q <= 1'b0;
      end else if (soft_rst) begin
         irq_req_q <= 1'b0;
      end else begin
         irq_req_q <= 1'b0;
      end
   end

   // ==========================================
   // Register read
   // Address decoded combinationally, data registered on the read strobe
   logic [`TGSP_DATA_W-1:0] rd_word;
   logic [N_PINS-1:0] in_mode;
   logic [N_PINS-1:0] in_level;

   // Pins not in input mode read zero
   // Driven pins would only echo the port's own level
   assign in_mode = ~drive_mask(oen_q, ien_q);
   assign in_level = level_q & in_mode;

   always_comb begin
      rd_word = `TGSP_RST_WORD;
      case (req.addr)
         `TGSP_ADDR_CTRL: begin
            rd_word[`TGSP_CTRL_ALT_BIT] = alt_en_q;
         end
         `TGSP_ADDR_DIR: begin
            rd_word = put_pins(rd_word, `TGSP_DIR_OEN_LSB, oen_q);
            rd_word = put_pins(rd_word, `TGSP_DIR_IEN_LSB, ien_q);
            rd_word = put_drv(rd_word, `TGSP_DIR_DRV_LSB, low_group_drive_strength_q);
         end
         `TGSP_ADDR_OUT: begin
            rd_word = put_pins(rd_word, `TGSP_OUT_VAL_LSB, val_q);
            rd_word = put_drv(rd_word, `TGSP_OUT_DRV_LSB, high_group_drive_strength_q);
         end
         `TGSP_ADDR_IN: begin
            rd_word = put_pins(rd_word, `TGSP_IN_VAL_LSB, in_level);
         end
         default: begin
            rd_word = `TGSP_RST_WORD;
         end
      endcase
   end

   // Strobe echoed one cycle on, whatever the address
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rvalid_q <= 1'b0;
      end else if (soft_rst) begin
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= req.rd;
      end
   end

   // ==========================================
   // Read data
   // Data holds until the next read strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_q <= `TGSP_RST_WORD;
      end else if (soft_rst) begin
         rdata_q <= `TGSP_RST_WORD;
      end else if (req.rd) begin
         rdata_q <= rd_word;
      end
   end

endmodule
`default_nettype wire

// File: verif/tgsp_port_asserts.sv
// Port checker for the pin port
`timescale 1ns/1ps
`default_nettype none
`include "tgsp_cfg.svh"
module tgsp_port_asserts #(
   parameter int N_PINS = 7
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic soft_rst,
   input wire tgsp_pkg::tgsp_req_t req,
   input wire logic [15:0] rdata_q,
   input wire logic rvalid_q,
   input wire tgsp_pkg::tgsp_seq_t seq,
   input wire logic [N_PINS-1:0] pin_in,
   input wire tgsp_pkg::tgsp_pad_t pad_q,
   input wire logic [1:0] low_group_drive_strength_q,
   input wire logic [1:0] high_group_drive_strength_q,
   input wire logic irq_req_q
);
   // ==========
   // Helpers
   logic wdir;
   logic ok;
   assign wdir = req.wr && req.addr == `TGSP_ADDR_DIR;
   assign ok = !soft_rst;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_irq_never: assert property (irq_req_q == 1'b0)
      else $error("irq raised");
   a_reset_idle: assert property (disable iff (1'b0) (rst || soft_rst) |=>
      pad_q == 14'h007f && low_group_drive_strength_q == 2'h0 && high_group_drive_strength_q == 2'h0)
      else $error("reset state wrong");
   a_read_pulse: assert property (ok |=> rvalid_q == $past(req.rd))
      else $error("rvalid wrong");
   a_rdata_hold: assert property (!req.rd && ok |=> $stable(rdata_q))
      else $error("rdata moved");
   a_low_drive: assert property (wdir && ok |=> low_group_drive_strength_q == $past(req.wdata[15:14]))
      else $error("low drive wrong");
   a_high_drive: assert property (req.wr && req.addr == `TGSP_ADDR_OUT && ok |=>
      high_group_drive_strength_q == $past(req.wdata[9:8]))
      else $error("high drive wrong");
   a_dir_apply: assert property (wdir && ok ##1 !wdir && ok |=>
      pad_q.oe_n == ~($past(req.wdata[6:0], 2) & ~$past(req.wdata[13:7], 2)))
      else $error("enable wrong");
   // Only a write may move the enables, sleep included
   a_pads_hold: assert property ((!req.wr && ok)[*2] |=> $stable(pad_q.oe_n))
      else $error("enable moved");
endmodule
`default_nettype wire

// File: verif/tgsp_pin_model.sv
// Board side of the seven pins
`timescale 1ns/1ps
`default_nettype none
module tgsp_pin_model (
   input wire tgsp_pkg::tgsp_pad_t pad,
   input wire logic [6:0] ext,
   output logic [6:0] pin_in
);
   // ==========
   // Pin levels
   // No pull-ups, so a released pin shows the board level
   assign pin_in = (pad.level & ~pad.oe_n) | (ext & pad.oe_n);
endmodule
`default_nettype wire

// File: verif/tgsp_port_bench.sv
// Self-checking bench for the pin port
`timescale 1ns/1ps
`default_nettype none
`include "tgsp_cfg.svh"
module tgsp_port_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic soft_rst = 1'b0;
   tgsp_pkg::tgsp_req_t req = '0;
   tgsp_pkg::tgsp_seq_t seq = '0;
   logic [6:0] ext = 7'h00;
   logic [6:0] pin_in;
   logic [15:0] rdata_q;
   logic rvalid_q;
   logic irq_req_q;
   tgsp_pkg::tgsp_pad_t pad_q;
   logic [1:0] lo_drv;
   logic [1:0] hi_drv;
   logic [5:0] adrs [5] = '{6'h09, 6'h0b, 6'h0c, 6'h28, 6'h3f};
   int ks [6] = '{1, 1, 2, 2, 0, 1};
   int fail_count = 0;
   int num_checks = 0;
   int m_ctrl;
   int m_dir;
   int m_out;
   logic r;
   always #2.5 clk = ~clk;
   tgsp_port uut (.clk(clk), .rst(rst), .soft_rst(soft_rst), .req(req), .rdata_q(rdata_q),
      .rvalid_q(rvalid_q), .seq(seq), .pin_in(pin_in), .pad_q(pad_q),
      .low_group_drive_strength_q(lo_drv), .high_group_drive_strength_q(hi_drv),
      .irq_req_q(irq_req_q));
   tgsp_pin_model pm (.pad(pad_q), .ext(ext), .pin_in(pin_in));
   // ==========
   // Tasks
   task automatic complete_run();
      if (fail_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic mreset();
      m_ctrl = 0;
      m_dir = 16'h3f80;
      m_out = 0;
   endtask
   function automatic logic [15:0] exp_rd(input logic [5:0] a);
      case (a)
         `TGSP_ADDR_CTRL: return 16'(m_ctrl) & 16'h0040;
         `TGSP_ADDR_DIR: return 16'(m_dir);
         `TGSP_ADDR_OUT: return 16'(m_out) & 16'h037f;
         `TGSP_ADDR_IN: return {9'h000, ext & ~(7'(m_dir) & ~7'(m_dir >> 7))};
         default: return 16'h0000;
      endcase
   endfunction
   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= {1'b1, 1'b0, a, d};
      @(posedge clk);
      req <= '0;
      case (a)
         `TGSP_ADDR_CTRL: m_ctrl = d;
         `TGSP_ADDR_DIR: m_dir = d;
         `TGSP_ADDR_OUT: m_out = d;
         default: ;
      endcase
   endtask
   task automatic rd_all();
      foreach (adrs[i]) begin
         @(posedge clk);
         req <= {1'b0, 1'b1, adrs[i], 16'h0000};
         @(posedge clk);
         req <= '0;
         #1;
         chk("rvalid", 16'h0001, {15'h0000, rvalid_q});
         chk("rdata", exp_rd(adrs[i]), rdata_q);
      end
   endtask
   task automatic chk_pad(input logic [1:0] st);
      logic [6:0] oe;
      logic [6:0] lv;
      @(posedge clk);
      #1;
      oe = ~(7'(m_dir) & ~7'(m_dir >> 7));
      lv = 7'(m_out);
      if (m_ctrl[6])
         lv[1:0] = st;
      chk("oe_n", {9'h000, oe}, {9'h000, pad_q.oe_n});
      chk("level", {9'h000, lv & ~oe}, {9'h000, pad_q.level & ~oe});
      chk("lo_drv", 16'(m_dir >> 14), {14'h0000, lo_drv});
      chk("hi_drv", 16'((m_out >> 8) & 3), {14'h0000, hi_drv});
      chk("irq", 16'h0000, {15'h0000, irq_req_q});
   endtask
   // ==========
   // Main sequence
   initial begin
      void'($urandom(32'h03e8fd40));
      mreset();
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd_all();
      for (int i = 0; i < 44; i++) begin
         wr(`TGSP_ADDR_DIR, i < 4 ? {i[1:0], 14'h0000} : 16'($urandom));
         wr(`TGSP_ADDR_OUT, i < 4 ? {6'h00, i[1:0], 8'h00} : 16'($urandom));
         wr(adrs[3 + i % 2], 16'($urandom));
         ext <= 7'($urandom);
         chk_pad(2'b00);
         rd_all();
      end
      wr(`TGSP_ADDR_DIR, 16'h007f);
      wr(`TGSP_ADDR_OUT, 16'h0000);
      wr(`TGSP_ADDR_CTRL, 16'h0040);
      foreach (ks[i]) begin
         r = i < 4 && i % 2 == 0;
         @(posedge clk);
         seq <= {1'b1, ks[i] == 1, ks[i] == 2, 4'h0};
         @(posedge clk);
         chk_pad(2'b01);
         @(posedge clk);
         seq <= {3'b000, i % 2 == 0, i % 2 == 0, i == 5, 1'b0};
         @(posedge clk);
         chk_pad({r, 1'b0});
         chk_pad({r, 1'b0});
      end
      @(posedge clk);
      seq <= 7'h41;
      @(posedge clk);
      chk_pad(2'b00);
      @(posedge clk);
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
      mreset();
      chk_pad(2'b00);
      rd_all();
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      complete_run();
   end
endmodule
bind tgsp_port tgsp_port_asserts #(.N_PINS(N_PINS)) chk_u (.clk(clk), .rst(rst),
   .soft_rst(soft_rst), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .seq(seq),
   .pin_in(pin_in), .pad_q(pad_q), .irq_req_q(irq_req_q),
   .low_group_drive_strength_q(low_group_drive_strength_q),
   .high_group_drive_strength_q(high_group_drive_strength_q));
`default_nettype wire
